// ### prcs_pkg.sv
// constants, types and reset values shared by the reference switchover ends
// Function
// R1 - auto mode: lost reference moves to backup
// R2 - export two lost flags and active indicator
// R3 - lost flag asserts when input stops toggling
// R4 - active indicator always shows feeding input
// R5 - auto switchover repeats back and forth unlimited
// R6 - user keeps both inputs running, within 20%
// R7 - both inputs dead: no switchover started
// R8 - stuck two cycles: flag lost, steer select
// R9 - beyond 100% apart, user switches by request
// R10 - gate old at its fall, switch at new fall
// R11 - override: indicator follows request, no lost flags (lost flags are exported in every mode; active changes only at a swap)
// R12 - act on request rising edge only
// R13 - switch completes only when target input runs
// R14 - manual: request decides, primary after reset
// R15 - request held high three reference cycles
// R16 - user returns request low after switch
// R17 - hold request three cycles of slower input
// R18 - hold three cycles plus configured delay cycles
// R19 - both inputs running when request rises
// R20 - pulse loop reset, await stable lock
package prcs_pkg;

  // system clock and timing
  localparam int SYS_PERIOD_NS = 100;
  localparam int LOOP_RST_NS = 10;
  localparam int LOOP_RST_CYC_I = (LOOP_RST_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [7:0] LOOP_RST_CYC = 8'(LOOP_RST_CYC_I < 1 ? 1 : LOOP_RST_CYC_I);
  localparam logic [7:0] LOCK_STABLE_CYC = 8'h10;

  // nominal reference period in system cycles, and the slower of the two
  localparam int REF_PERIOD_CYC = 8;
  localparam logic [4:0] LOST_CYC = 5'(2 * REF_PERIOD_CYC);
  localparam logic [7:0] SLOW_REF_PERIOD_CYC = 8'h08;

  // request qualification
  localparam logic [3:0] HOLD_BASE = 4'h3;

  // operating modes
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_OVERRIDE = 2'h2;

  typedef enum logic [2:0] {
    DEV_RUN = 3'h1,
    DEV_GATE = 3'h2,
    DEV_SWAP = 3'h4
  } prcs_dev_state_t;

  typedef enum logic [3:0] {
    USR_IDLE = 4'h1,
    USR_HOLD = 4'h2,
    USR_RST = 4'h4,
    USR_LOCK = 4'h8
  } prcs_usr_state_t;

  typedef struct packed {
    logic prev;
    logic [4:0] cnt;
    logic lost;
    logic rise;
    logic fall;
  } prcs_sense_t;

  typedef struct packed {
    prcs_dev_state_t st;
    logic sel;
    logic gate;
    logic ref_out;
    logic req_prev;
    logic armed;
    logic [3:0] qcnt;
    logic [1:0] lost;
    logic active;
    logic lock;
    logic loop_rst;
    logic busy;
  } prcs_dev_t;

  typedef struct packed {
    prcs_usr_state_t st;
    logic pend;
    logic req;
    logic rst;
    logic out_en;
    logic [7:0] cnt;
    logic active_seen;
    logic active;
    logic [1:0] lost;
    logic busy;
  } prcs_usr_t;

  localparam prcs_sense_t SENSE_RESET = '{prev: 1'b0, cnt: 5'h00, lost: 1'b0,
                                          rise: 1'b0, fall: 1'b0};

  // primary input selected and passed through after reset
  localparam prcs_dev_t DEV_RESET = '{st: DEV_RUN, sel: 1'b0, gate: 1'b1, ref_out: 1'b0,
                                      req_prev: 1'b0, armed: 1'b0, qcnt: 4'h0,
                                      lost: 2'h0, active: 1'b0, lock: 1'b0,
                                      loop_rst: 1'b0, busy: 1'b0};

  localparam prcs_usr_t USR_RESET = '{st: USR_IDLE, pend: 1'b0, req: 1'b0, rst: 1'b0,
                                      out_en: 1'b0, cnt: 8'h00, active_seen: 1'b0,
                                      active: 1'b0, lost: 2'h0, busy: 1'b0};

endpackage : prcs_pkg

// ### prcs_link_if.sv
// link between the switchover device and the user control logic
`timescale 1ns/100ps
`default_nettype none
interface prcs_link_if;
  logic switch_req;
  logic loop_rst_req;
  logic [1:0] lost;
  logic active;
  logic lock;

  modport dev (
    input switch_req,
    input loop_rst_req,
    output lost,
    output active,
    output lock
  );

  modport usr (
    output switch_req,
    output loop_rst_req,
    input lost,
    input active,
    input lock
  );
endinterface : prcs_link_if
`default_nettype wire

// ### prcs_sense.sv
// activity sense for one reference input sampled on the system clock
`timescale 1ns/100ps
`default_nettype none
module prcs_sense (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ref_i,
  output logic lost_o,
  output logic rise_o,
  output logic fall_o
);
  prcs_pkg::prcs_sense_t s_q;
  prcs_pkg::prcs_sense_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.prev = ref_i;
    s_d.rise = ref_i & ~s_q.prev;
    s_d.fall = ~ref_i & s_q.prev;
    if (ref_i != s_q.prev) begin
      s_d.cnt = 5'h00;
    end else if (s_q.cnt != prcs_pkg::LOST_CYC) begin
      s_d.cnt = s_q.cnt + 5'h01;
    end
    // flag holds while the input stays flat and drops at the first edge
    s_d.lost = (s_d.cnt == prcs_pkg::LOST_CYC); // [R3] [R8]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= prcs_pkg::SENSE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign lost_o = s_q.lost;
  assign rise_o = s_q.rise;
  assign fall_o = s_q.fall;
endmodule : prcs_sense
`default_nettype wire

// ### prcs_dev.sv
// reference clock switchover device: clock sense, select state machine, gated mux
`timescale 1ns/100ps
`default_nettype none
module prcs_dev (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic PRIMARY_REF_INPUT_I,
  input wire logic BACKUP_REF_INPUT_I,
  input wire logic [1:0] MODE_I,
  input wire logic [2:0] SW_DELAY_I,
  input wire logic LOCK_I,
  output logic REF_CLK_O,
  output logic LOOP_RESET_O,
  output logic SWITCHING_O,
  prcs_link_if.dev link
);
  logic [1:0] ref_in;
  logic [1:0] lost;
  logic [1:0] rise;
  logic [1:0] fall;

  prcs_pkg::prcs_dev_t s_q;
  prcs_pkg::prcs_dev_t s_d;

  assign ref_in = {BACKUP_REF_INPUT_I, PRIMARY_REF_INPUT_I};

  // one sense block per reference input
  for (genvar i = 0; i < 2; i++) begin : g_sense
    prcs_sense prcs_sense_inst (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RESETN_I),
      .ref_i(ref_in[i]),
      .lost_o(lost[i]),
      .rise_o(rise[i]),
      .fall_o(fall[i])
    );
  end

  logic old_idx;
  logic new_idx;
  logic req_rise;
  logic man_ok;
  logic auto_ok;
  logic auto_trig;
  logic man_trig;
  logic [3:0] hold_lim;

  always_comb begin
    old_idx = s_q.sel;
    new_idx = ~s_q.sel;
    req_rise = link.switch_req & ~s_q.req_prev;
    man_ok = (MODE_I == prcs_pkg::MODE_MANUAL) || (MODE_I == prcs_pkg::MODE_OVERRIDE);
    // in override mode a high request suspends automatic switching
    auto_ok = (MODE_I == prcs_pkg::MODE_AUTO)
      || ((MODE_I == prcs_pkg::MODE_OVERRIDE) && !link.switch_req);
    // both inputs flat: no switchover is begun
    auto_trig = auto_ok && lost[old_idx] && !lost[new_idx]; // [R1] [R5] [R7] [R8]
    hold_lim = prcs_pkg::HOLD_BASE + {1'b0, SW_DELAY_I}; // [R18]
    man_trig = s_q.armed && link.switch_req && rise[old_idx]
      && ((s_q.qcnt + 4'h1) == hold_lim); // [R15]
  end

  always_comb begin
    s_d = s_q;
    s_d.req_prev = link.switch_req;
    s_d.lost = lost; // [R2] [R3]
    s_d.lock = LOCK_I;
    s_d.loop_rst = link.loop_rst_req;

    // request qualification: armed by a rising edge only
    if (!man_ok || !link.switch_req) begin
      s_d.armed = 1'b0;
      s_d.qcnt = 4'h0;
    end else if (req_rise && s_q.st == prcs_pkg::DEV_RUN) begin
      s_d.armed = 1'b1; // [R12] [R14]
      s_d.qcnt = 4'h0;
    end else if (s_q.armed && rise[old_idx]) begin
      s_d.qcnt = s_q.qcnt + 4'h1; // [R15] [R18]
    end

    unique case (s_q.st)
      prcs_pkg::DEV_RUN: begin
        if (man_trig) begin
          // one swap per rising edge; the falling edge never swaps back
          s_d.armed = 1'b0; // [R12] [R11]
          s_d.qcnt = 4'h0;
          s_d.st = prcs_pkg::DEV_GATE;
        end else if (auto_trig) begin
          s_d.st = prcs_pkg::DEV_GATE; // [R1] [R5]
        end
      end
      prcs_pkg::DEV_GATE: begin
        // a dead old input has no falling edge, so gate off at once
        if (fall[old_idx] || lost[old_idx]) begin
          s_d.gate = 1'b0; // [R10]
          s_d.st = prcs_pkg::DEV_SWAP;
        end
      end
      prcs_pkg::DEV_SWAP: begin
        // wait here for as long as the target input is not running
        if (!lost[new_idx] && fall[new_idx]) begin
          s_d.sel = new_idx; // [R10] [R13]
          s_d.active = new_idx; // [R4] [R11]
          s_d.gate = 1'b1;
          s_d.st = prcs_pkg::DEV_RUN;
        end
      end
    endcase

    s_d.busy = (s_d.st != prcs_pkg::DEV_RUN);
    // output is held low while gated, so no runt pulse can reach the loop
    s_d.ref_out = s_d.gate & ref_in[s_d.sel]; // [R10]
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_q <= prcs_pkg::DEV_RESET; // [R14]
    end else begin
      s_q <= s_d;
    end
  end

  assign REF_CLK_O = s_q.ref_out;
  assign LOOP_RESET_O = s_q.loop_rst;
  assign SWITCHING_O = s_q.busy;
  assign link.lost = s_q.lost;
  assign link.active = s_q.active;
  assign link.lock = s_q.lock;
endmodule : prcs_dev
`default_nettype wire

// ### prcs_user.sv
// user control end: issues switch requests and recovers the loop after a switch
`timescale 1ns/100ps
`default_nettype none
module prcs_user (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic SWITCH_CMD_I,
  input wire logic [2:0] SW_DELAY_I,
  output logic OUT_EN_O,
  output logic ACTIVE_O,
  output logic [1:0] LOST_O,
  output logic BUSY_O,
  prcs_link_if.usr link
);
  prcs_pkg::prcs_usr_t s_q;
  prcs_pkg::prcs_usr_t s_d;
  logic [7:0] hold_lim;

  always_comb begin
    // hold measured in cycles of the slower input, delay included
    hold_lim = 8'((prcs_pkg::HOLD_BASE + {1'b0, SW_DELAY_I})
      * prcs_pkg::SLOW_REF_PERIOD_CYC); // [R17] [R18] [R15]
    s_d = s_q;
    s_d.active = link.active;
    s_d.lost = link.lost;
    if (SWITCH_CMD_I) begin
      s_d.pend = 1'b1;
    end
    unique case (s_q.st)
      prcs_pkg::USR_IDLE: begin
        if (link.active != s_q.active_seen) begin
          s_d.active_seen = link.active;
          s_d.rst = 1'b1; // [R20]
          s_d.out_en = 1'b0;
          s_d.cnt = 8'h00;
          s_d.st = prcs_pkg::USR_RST;
        end else if (s_q.pend && link.lost == 2'h0) begin
          // only request while both inputs run
          s_d.pend = SWITCH_CMD_I; // [R19] [R9]
          s_d.req = 1'b1;
          s_d.cnt = 8'h00;
          s_d.st = prcs_pkg::USR_HOLD;
        end
      end
      prcs_pkg::USR_HOLD: begin
        s_d.cnt = s_q.cnt + 8'h01;
        if (s_d.cnt == hold_lim + 8'h01) begin
          s_d.req = 1'b0; // [R16]
          s_d.st = prcs_pkg::USR_IDLE;
        end
      end
      prcs_pkg::USR_RST: begin
        s_d.cnt = s_q.cnt + 8'h01;
        if (s_d.cnt == prcs_pkg::LOOP_RST_CYC) begin
          s_d.rst = 1'b0; // [R20]
          s_d.cnt = 8'h00;
          s_d.st = prcs_pkg::USR_LOCK;
        end
      end
      prcs_pkg::USR_LOCK: begin
        s_d.cnt = link.lock ? s_q.cnt + 8'h01 : 8'h00;
        if (s_d.cnt == prcs_pkg::LOCK_STABLE_CYC) begin
          s_d.out_en = 1'b1; // [R20]
          s_d.st = prcs_pkg::USR_IDLE;
        end
      end
    endcase
    s_d.busy = (s_d.st != prcs_pkg::USR_IDLE);
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_q <= prcs_pkg::USR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.switch_req = s_q.req;
  assign link.loop_rst_req = s_q.rst;
  assign OUT_EN_O = s_q.out_en;
  assign ACTIVE_O = s_q.active;
  assign LOST_O = s_q.lost;
  assign BUSY_O = s_q.busy;
endmodule : prcs_user
`default_nettype wire

// ### prcs_link_assertions.sv
// concurrent checks on the link between the two switchover ends
`timescale 1ns/100ps
`default_nettype none
module prcs_link_chk (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic switch_req,
  input wire logic loop_rst_req,
  input wire logic [1:0] lost,
  input wire logic active,
  input wire logic lock
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESETN_I);

  sequence s_req_start;
    $rose(switch_req);
  endsequence

  // shortest legal hold is three reference periods of 8 cycles
  sequence s_req_hold;
    switch_req [*8] ##16 switch_req;
  endsequence

  AST_REQ_HOLD: assert property (s_req_start |-> s_req_hold)
    else $error("switch request dropped too early");
  AST_REQ_DROP: assert property (s_req_start |-> ##[25:90] !switch_req)
    else $error("switch request never returned low");
  AST_REQ_HEALTHY: assert property (s_req_start |-> $past(lost) == 2'h0)
    else $error("switch request raised with a lost input");
  AST_REQ_NO_LOST: assert property (switch_req |-> lost == 2'h0)
    else $error("lost flag during requested switch");
  AST_RST_PULSE: assert property ($rose(loop_rst_req) |=> !loop_rst_req)
    else $error("loop reset pulse too long");
  AST_RST_AFTER_SWAP: assert property ($changed(active) |-> ##[1:300] $rose(loop_rst_req))
    else $error("no loop reset after switchover");
  AST_BOTH_LOST_HOLD: assert property (lost == 2'h3 |=> $stable(active))
    else $error("switchover with both inputs lost");
  AST_TARGET_RUNS: assert property ($changed(active) |-> !lost[active])
    else $error("switched to a lost input");

  COV_RELOCK: cover property (lock && $rose(loop_rst_req));
endmodule : prcs_link_chk
`default_nettype wire

// ### tb_pll_reference_clock_switchover.sv
// testbench joining the switchover device and the user control end
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_pll_reference_clock_switchover;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pri = 1'b0;
  logic bak = 1'b0;
  logic pri_run = 1'b1;
  logic bak_run = 1'b1;
  logic [1:0] mode = prcs_pkg::MODE_AUTO;
  logic [2:0] dly = 3'h0;
  logic [2:0] dly_f = 3'h0;
  logic cmd = 1'b0;
  logic lock = 1'b1;
  int ph = 0;
  int fail_count = 0;
  int num_checks = 0;
  logic out_en;
  logic act;
  logic sw;
  logic ref_o;
  logic loop_rst;
  logic ubusy;
  int rst_pulses = 0;
  logic [1:0] lost;
  wire logic [3:0] watch;
  assign watch = {out_en, lost, act};

  prcs_link_if prcs_link_if_inst ();
  prcs_link_if prcs_link_if_f_inst ();
  prcs_dev prcs_dev_inst (.CLK_SYS_I(clk), .RESETN_I(rst_n), .PRIMARY_REF_INPUT_I(pri),
    .BACKUP_REF_INPUT_I(bak), .MODE_I(mode), .SW_DELAY_I(dly), .LOCK_I(lock),
    .REF_CLK_O(ref_o), .LOOP_RESET_O(loop_rst), .SWITCHING_O(sw), .link(prcs_link_if_inst.dev));
  // second device faces the bench alone so requests can break the hold rules
  prcs_dev prcs_dev_f_inst (.CLK_SYS_I(clk), .RESETN_I(rst_n), .PRIMARY_REF_INPUT_I(pri),
    .BACKUP_REF_INPUT_I(bak), .MODE_I(prcs_pkg::MODE_MANUAL), .SW_DELAY_I(dly_f),
    .LOCK_I(lock), .REF_CLK_O(), .LOOP_RESET_O(), .SWITCHING_O(),
    .link(prcs_link_if_f_inst.dev));
  prcs_user prcs_user_inst (.CLK_SYS_I(clk), .RESETN_I(rst_n), .SWITCH_CMD_I(cmd),
    .SW_DELAY_I(dly), .OUT_EN_O(out_en), .ACTIVE_O(act), .LOST_O(lost), .BUSY_O(ubusy),
    .link(prcs_link_if_inst.usr));
  prcs_link_chk prcs_link_chk_inst (.CLK_SYS_I(clk), .RESETN_I(rst_n),
    .switch_req(prcs_link_if_inst.switch_req), .loop_rst_req(prcs_link_if_inst.loop_rst_req),
    .lost(prcs_link_if_inst.lost), .active(prcs_link_if_inst.active),
    .lock(prcs_link_if_inst.lock));

  initial forever #50 clk = ~clk;

  // both references run from the start with period 8, offset by 2 cycles
  always @(negedge clk) begin
    ph <= ph + 1;
    if (ph % 4 == 0 && pri_run) pri <= ~pri;
    if (ph % 4 == 2 && bak_run) bak <= ~bak;
  end

  // each loop reset pulse lasts one cycle, so it is seen at exactly one falling edge
  always @(negedge clk) begin
    if (loop_rst === 1'b1) rst_pulses <= rst_pulses + 1;
  end

  task automatic summarize;
    $display("checks %0d fails %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic wt(input int b, input logic v);
    int i;
    for (i = 0; i < 400 && watch[b] !== v; i++) @(negedge clk);
    if (i == 400) begin
      fail_count++;
      $display("[FAIL] wait bit %0d exp %0h got %0h", b, v, watch[b]);
      summarize();
    end
  endtask : wt

  task automatic pulse_f(input int n);
    prcs_link_if_f_inst.switch_req = 1'b1;
    repeat (n) @(negedge clk);
    prcs_link_if_f_inst.switch_req = 1'b0;
    repeat (60) @(negedge clk);
  endtask : pulse_f

  task automatic t_reset;
    `CHK("active", 1'b0, act)
    `CHK("lost", 2'h0, lost)
    `CHK("ref out", pri, ref_o)
  endtask : t_reset

  task automatic t_fault;
    pulse_f(16);
    `CHK("short req", 1'b0, prcs_link_if_f_inst.active)
    pulse_f(200);
    `CHK("held req", 1'b1, prcs_link_if_f_inst.active)
    dly_f = 3'h7;
    pulse_f(40);
    `CHK("delayed req", 1'b1, prcs_link_if_f_inst.active)
    dly_f = 3'h0;
    pulse_f(200);
    `CHK("second req", 1'b0, prcs_link_if_f_inst.active)
  endtask : t_fault

  task automatic t_auto;
    pri_run = 1'b0;
    wt(0, 1'b1);
    `CHK("lost pri", 1'b1, lost[0])
    `CHK("ref out bak", bak, ref_o)
    // a lock that drops during relock must restart the settle count
    lock = 1'b0;
    repeat (30) @(negedge clk);
    `CHK("out_en unlocked", 1'b0, out_en)
    lock = 1'b1;
    wt(3, 1'b1);
    pri_run = 1'b1;
    wt(1, 1'b0);
    bak_run = 1'b0;
    wt(0, 1'b0);
    `CHK("lost bak", 1'b1, lost[1])
    bak_run = 1'b1;
    wt(2, 1'b0);
  endtask : t_auto

  task automatic t_dead;
    bak_run = 1'b0;
    repeat (4) @(negedge clk);
    pri_run = 1'b0;
    repeat (60) @(negedge clk);
    `CHK("dead active", 1'b0, act)
    `CHK("dead switching", 1'b0, sw)
    bak_run = 1'b1;
    wt(0, 1'b1);
    pri_run = 1'b1;
    wt(1, 1'b0);
    wt(3, 1'b1);
  endtask : t_dead

  task automatic t_manual;
    for (int k = 0; k < 3; k++) begin
      mode = (k == 2) ? prcs_pkg::MODE_OVERRIDE : prcs_pkg::MODE_MANUAL;
      dly = (k == 1) ? 3'h3 : 3'h0;
      cmd = 1'b1;
      @(negedge clk);
      cmd = 1'b0;
      wt(0, logic'(k % 2));
      `CHK("manual lost", 2'h0, lost)
      repeat (4) @(negedge clk);
      wt(3, 1'b1);
      `CHK("user busy", 1'b0, ubusy)
    end
  endtask : t_manual

  task automatic t_override;
    // override mode with the request low still switches away from a lost input
    pri_run = 1'b0;
    wt(0, 1'b1);
    pri_run = 1'b1;
    wt(1, 1'b0);
    wt(3, 1'b1);
    `CHK("loop resets", 32'h7, rst_pulses)
  endtask : t_override

  initial begin
    prcs_link_if_f_inst.switch_req = 1'b0;
    prcs_link_if_f_inst.loop_rst_req = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_fault();
    t_auto();
    t_dead();
    t_manual();
    t_override();
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule : tb_pll_reference_clock_switchover
`default_nettype wire
